// file: ieb4_enable_bank.v
// Interrupt enable bank four: per-source enables gating six peripheral requests,
// sticky event status with write-one-to-clear, and one level interrupt output.
// Assumes requests are synchronous levels and the register master never waits.
//
// Functional notes
// - One passes a request, zero blocks it
// - Bit 6 gates first network transmit request
// - Bit 5 gates DMA channel 7 done
// - Enable bits read/write, cleared at reset
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ieb4_defines.vh"

module ieb4_enable_bank #(
   parameter AW = 4,
   parameter DW = 16
) (
   // Clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // Register port
   input wire [AW-1:0] i_addr,
   input wire [DW-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire [DW-1:0] o_rdata,
   // Raw peripheral requests
   input wire i_can_one_tx_req,
   input wire i_can_two_tx_req,
   input wire i_dma_ch6_done,
   input wire i_dma_ch7_done,
   input wire i_uart_one_err,
   input wire i_uart_two_err,
   // Gated requests towards the controller
   output wire o_can_one_tx_req_gated,
   output wire o_can_two_tx_req_gated,
   output wire o_dma_ch6_done_gated,
   output wire o_dma_ch7_done_gated,
   output wire o_uart_one_err_gated,
   output wire o_uart_two_err_gated,
   // Summary interrupt
   output wire o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helper

   // Address match, used by the write decode; the read path decodes with a case
   function addr_is;
      input [AW-1:0] a;
      input [AW-1:0] want;
      begin
         addr_is = (a == want);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Raw request vector

   wire [DW-1:0] raw_req;

   // Bit map shared by the enable, status and pending registers:
   //   7  second network module transmit request
   //   6  first network module transmit request
   //   5  DMA channel 7 transfer done
   //   4  DMA channel 6 transfer done
   //   2  second UART error
   //   1  first UART error
   //   15-8, 3, 0  unused, always zero
   // Place each source at its enable bit; unmapped bits stay zero
   assign raw_req[15:8] = 8'h00;
   assign raw_req[`IEB4_BIT_CAN_TWO_TX] = i_can_two_tx_req;
   assign raw_req[`IEB4_BIT_CAN_ONE_TX] = i_can_one_tx_req;
   assign raw_req[`IEB4_BIT_DMA_CH7_DONE] = i_dma_ch7_done;
   assign raw_req[`IEB4_BIT_DMA_CH6_DONE] = i_dma_ch6_done;
   assign raw_req[3] = 1'b0;
   assign raw_req[`IEB4_BIT_UART_TWO_ERR] = i_uart_two_err;
   assign raw_req[`IEB4_BIT_UART_ONE_ERR] = i_uart_one_err;
   assign raw_req[0] = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Write decode

   wire wr_enable;
   wire wr_status;

   // One strobe each for enable and status; writes to pending or unmapped addresses decode to nothing
   assign wr_enable = i_wr & addr_is(i_addr, `IEB4_ADDR_ENABLE);
   assign wr_status = i_wr & addr_is(i_addr, `IEB4_ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Enable register

   reg [DW-1:0] enable_r;
   wire [DW-1:0] enable_nxt;

   // Software owns this register alone; hardware never changes it
   // Unimplemented bits never store, so they always read zero
   assign enable_nxt = wr_enable ? (i_wdata & `IEB4_IMPL_MASK) : enable_r;

   // All sources start disabled
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         enable_r <= `IEB4_ENABLE_RESET;
      end else begin
         enable_r <= enable_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gated request outputs

   wire [DW-1:0] gated;

   // One flop per position; the same gate repeats across the word
   genvar g;
   generate
      for (g = 0; g < DW; g = g + 1) begin : gate_bit
         reg bit_r;
         wire bit_nxt;

         // Registered for clean outputs; costs one cycle of latency
         assign bit_nxt = raw_req[g] & enable_r[g];

         // Unused positions see a zero request and stay low
         always @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               bit_r <= 1'b0;
            end else begin
               bit_r <= bit_nxt;
            end
         end

         assign gated[g] = bit_r;
      end
   endgenerate

   // Only the six live positions leave the block
   assign o_can_two_tx_req_gated = gated[`IEB4_BIT_CAN_TWO_TX];
   assign o_can_one_tx_req_gated = gated[`IEB4_BIT_CAN_ONE_TX];
   assign o_dma_ch7_done_gated = gated[`IEB4_BIT_DMA_CH7_DONE];
   assign o_dma_ch6_done_gated = gated[`IEB4_BIT_DMA_CH6_DONE];
   assign o_uart_two_err_gated = gated[`IEB4_BIT_UART_TWO_ERR];
   assign o_uart_one_err_gated = gated[`IEB4_BIT_UART_ONE_ERR];

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event status

   wire [DW-1:0] status;
   wire [DW-1:0] status_clr;

   // Write one to clear; a raw event in the same cycle keeps the bit
   assign status_clr = wr_status ? (i_wdata & `IEB4_IMPL_MASK) : {DW{1'b0}};

   ieb4_sticky #(
      .WIDTH(DW),
      .RESET_VAL(`IEB4_STATUS_RESET)
   ) u_status (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_set(raw_req),
      .i_clear(status_clr),
      .o_flags(status)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pending view and interrupt

   wire [DW-1:0] pending;

   // The enable register doubles as the mask, so a disabled source still
   // latches status and fires as soon as software enables it
   assign pending = status & enable_r;

   // Level interrupt while any enabled event is latched
   assign o_irq = |pending;

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   reg [DW-1:0] rdata_r;
   reg [DW-1:0] rdata_nxt;

   // Data valid only in the cycle after the read strobe
   always @* begin
      rdata_nxt = {DW{1'b0}};
      // With no strobe the port rests at zero, so stale data never shows
      if (i_rd) begin
         case (i_addr)
            `IEB4_ADDR_ENABLE: begin
               rdata_nxt = enable_r;
            end
            `IEB4_ADDR_STATUS: begin
               rdata_nxt = status;
            end
            `IEB4_ADDR_PENDING: begin
               rdata_nxt = pending;
            end
            default: begin
               // Unmapped addresses read as zero
               rdata_nxt = {DW{1'b0}};
            end
         endcase
      end
   end

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_r <= `IEB4_RDATA_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

endmodule

`default_nettype wire

// file: ieb4_defines.vh
// Constants for the interrupt enable bank: addresses, bit positions, reset values.
// Assumes a 4-bit word address on the plain register port and 16-bit data.
`ifndef IEB4_DEFINES_VH
`define IEB4_DEFINES_VH

// Register word addresses
`define IEB4_ADDR_ENABLE 4'h0
`define IEB4_ADDR_STATUS 4'h1
`define IEB4_ADDR_PENDING 4'h2

// Field positions inside the 16-bit registers
`define IEB4_BIT_UART_ONE_ERR 1
`define IEB4_BIT_UART_TWO_ERR 2
`define IEB4_BIT_DMA_CH6_DONE 4
`define IEB4_BIT_DMA_CH7_DONE 5
`define IEB4_BIT_CAN_ONE_TX 6
`define IEB4_BIT_CAN_TWO_TX 7

// Implemented bits; all others read as zero
`define IEB4_IMPL_MASK 16'h00F6

// Reset values
`define IEB4_ENABLE_RESET 16'h0000
`define IEB4_STATUS_RESET 16'h0000
`define IEB4_RDATA_RESET 16'h0000

`endif

// file: ieb4_sticky.v
// Sticky flag bank: bits set by hardware events, cleared by writing a one.
// Assumes set and clear strobes are synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none

module ieb4_sticky #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // Set and clear
   input wire [WIDTH-1:0] i_set,
   input wire [WIDTH-1:0] i_clear,
   // Flag state
   output wire [WIDTH-1:0] o_flags
);

   reg [WIDTH-1:0] flags_r;
   wire [WIDTH-1:0] flags_nxt;

   // Set wins over clear so an event in the clearing cycle is kept
   assign flags_nxt = (flags_r & ~i_clear) | i_set;

   // Flag storage
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flags_r <= RESET_VAL;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign o_flags = flags_r;

endmodule

`default_nettype wire

// file: ieb4_props_properties.sv
// Checker for the enable bank: gating, readback, unused bits.
// Assumes it is bound to every ieb4_enable_bank instance.
`timescale 1ns/1ns
`default_nettype none
module ieb4_props #(parameter AW = 4, parameter DW = 16) (
   // Clock, reset, register port
   input wire i_clk, input wire i_reset_n, input wire [AW-1:0] i_addr,
   input wire [DW-1:0] i_wdata, input wire i_wr, input wire i_rd, input wire [DW-1:0] o_rdata,
   // Requests in and out
   input wire i_can_one_tx_req, input wire i_can_two_tx_req, input wire i_dma_ch6_done,
   input wire i_dma_ch7_done, input wire i_uart_one_err, input wire i_uart_two_err,
   input wire o_can_one_tx_req_gated, input wire o_can_two_tx_req_gated,
   input wire o_dma_ch6_done_gated, input wire o_dma_ch7_done_gated,
   input wire o_uart_one_err_gated, input wire o_uart_two_err_gated, input wire o_irq
);
   reg [15:0] en_r;
   // Enable mirror; masks unused bits as the design must
   always @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n) en_r <= 16'h0000;
      else if (i_wr && i_addr == 4'h0) en_r <= i_wdata & 16'h00f6;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////
   zero_blocks_a: assert property ($past(en_r[5:4] == 2'h0) |->
      !o_dma_ch7_done_gated && !o_dma_ch6_done_gated) else $error("blocked request passed");
   can_one_gate_a: assert property (o_can_one_tx_req_gated ==
      $past(i_can_one_tx_req & en_r[6])) else $error("can one gate wrong");
   ch7_gate_a: assert property (o_dma_ch7_done_gated ==
      $past(i_dma_ch7_done & en_r[5])) else $error("ch7 gate wrong");
   ch6_gate_a: assert property (o_dma_ch6_done_gated ==
      $past(i_dma_ch6_done & en_r[4])) else $error("ch6 gate wrong");
   enable_readback_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == $past(en_r))
      else $error("enable readback wrong");
   other_gates_a: assert property ({o_can_two_tx_req_gated, o_uart_two_err_gated,
      o_uart_one_err_gated} == $past({i_can_two_tx_req, i_uart_two_err, i_uart_one_err}
      & {en_r[7], en_r[2], en_r[1]})) else $error("other gates wrong");
   unused_zero_a: assert property (o_rdata[15:8] == 8'h00 && !o_rdata[3] && !o_rdata[0])
      else $error("unused bits set");
endmodule
bind ieb4_enable_bank ieb4_props #(.AW(AW), .DW(DW)) ieb4_props_i (.*);
`default_nettype wire

// file: tb_interrupt_enable_bank_four.sv
// Testbench for the enable bank: reset, readback, gating, interrupt.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_enable_bank_four;
   reg i_clk = 1'h0, i_reset_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
   reg [3:0] i_addr = 4'h0;
   reg [15:0] i_wdata = 16'h0000;
   reg [5:0] raw = 6'h00;
   wire [15:0] o_rdata;
   wire o_irq, o_can_one_tx_req_gated, o_can_two_tx_req_gated, o_dma_ch6_done_gated;
   wire o_dma_ch7_done_gated, o_uart_one_err_gated, o_uart_two_err_gated;
   // Raw requests, index k sits at register bit pos(k)
   wire i_uart_one_err = raw[0], i_uart_two_err = raw[1], i_dma_ch6_done = raw[2];
   wire i_dma_ch7_done = raw[3], i_can_one_tx_req = raw[4], i_can_two_tx_req = raw[5];
   wire [5:0] gated = {o_can_two_tx_req_gated, o_can_one_tx_req_gated, o_dma_ch7_done_gated,
      o_dma_ch6_done_gated, o_uart_two_err_gated, o_uart_one_err_gated};
   integer n_fail = 0, n_tests = 0, k;
   ieb4_enable_bank ieb4_enable_bank_i (.*);
   // Clock and a hang guard
   initial forever #5 i_clk = ~i_clk;
   initial begin
      #100000;
      n_fail = n_fail + 1;
      stop_test;
   end
   ////////////////////////////////////////////////
   task stop_test;
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'h1, a, d};
      @(posedge i_clk) i_wr <= 1'h0;
   endtask
   task rd(input [3:0] a, input [15:0] e);
      @(posedge i_clk) {i_rd, i_addr} <= {1'h1, a};
      @(posedge i_clk) i_rd <= 1'h0;
      #1 chk("rdata", e, o_rdata);
   endtask
   // Requests fire with one source enabled at a time
   task t_gate;
      for (k = 0; k < 6; k = k + 1) begin
         wr(4'h0, 16'h0001 << (k < 2 ? k + 1 : k + 2));
         @(posedge i_clk) raw <= 6'h3f;
         @(posedge i_clk) raw <= 6'h00;
         #1 chk("gated", 16'h0001 << k, {10'h000, gated});
      end
      wr(4'h0, 16'h0000);
      @(posedge i_clk) raw <= 6'h3f;
      @(posedge i_clk) raw <= 6'h00;
      #1 chk("gated", 16'h0000, {10'h000, gated});
   endtask
   // Sticky status, mask, then clear drops the line
   task t_irq;
      wr(4'h1, 16'hffff);
      @(posedge i_clk) raw <= 6'h01;
      @(posedge i_clk) raw <= 6'h00;
      rd(4'h1, 16'h0002);
      chk("irq", 16'h0000, o_irq);
      wr(4'h0, 16'h0002);
      #1 chk("irq", 16'h0001, o_irq);
      rd(4'h2, 16'h0002);
      wr(4'h1, 16'h0002);
      #1 chk("irq", 16'h0000, o_irq);
      rd(4'h1, 16'h0000);
      // Clear in the same cycle as a fresh event: the event wins
      @(posedge i_clk) raw <= 6'h01;
      wr(4'h1, 16'h0002);
      raw <= 6'h00;
      rd(4'h1, 16'h0002);
      wr(4'h1, 16'h0002);
      rd(4'h1, 16'h0000);
   endtask
   // Main sequence; reset held two cycles
   initial begin
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'h1;
      rd(4'h0, 16'h0000);
      rd(4'h9, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h00f6);
      t_gate;
      t_irq;
      stop_test;
   end
endmodule
`default_nettype wire
